/* File: rtl/msc_pkg.sv */
// Package of constants and types for the special control register bank
package msc_pkg;
    // Core register-access commands
    typedef enum logic [3:0] {
        CMD_NONE, CMD_OP_RD, CMD_OP_WR, CMD_PORT_RD, CMD_PORT_WR,
        CMD_CTRL_RD, CMD_CTRL_WR, CMD_IRQ_DIS, CMD_IRQ_EN, CMD_IRQ_RET
    } msc_cmd_t;
    // Operation modes held in the mode field
    typedef enum logic [1:0] {
        MODE_DETECT, MODE_USB, MODE_KEYBOARD, MODE_USB_TEST
    } msc_mode_t;
    // One request from the core
    typedef struct packed {
        msc_cmd_t   cmd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } msc_req_t;
    // Events and levels from the USB engine
    typedef struct packed {
        logic rxDone;      // Engine finished a FIFO write
        logic ep0Cmd;      // Vendor or class command seen
        logic suspendDet;  // Suspend detected
        logic busReset;    // Host drives bus reset
        logic hostSuspend; // Suspend level
        logic busIdle;     // Bus idle level
        logic wakeDisSet;  // Engine sets port-wake disable
    } msc_usb_ev_t;
    // Control levels driven to the rest of the chip
    typedef struct packed {
        logic [4:0][7:0] portDirIn;   // 1 = input, ports 5..9
        msc_mode_t       opMode;
        logic            patternDetectEnable;
        logic            extraBankSelect;
        logic [1:0]      dualFreq;
        logic [6:0]      p9WakeEn;
        logic [6:0]      p9LedSink;
        logic            upperLedSink; // Pins 76 and 77
        logic [6:0]      p9PullEn;
        logic [2:0]      p568PullEn;   // Ports 5, 6, 8
        logic            deviceResume;
        logic            clockRun;
        logic            watchdogEnable;
        logic            portWakeEn;
        logic            normalClock;
    } msc_pins_t;
    // Operation register addresses
    localparam logic [3:0] OP_STATUS  = 4'hc;
    localparam logic [3:0] OP_POINTER = 4'hd;
    localparam logic [3:0] OP_WINDOW  = 4'he;
    localparam logic [3:0] OP_FLAGS   = 4'hf;
    localparam logic [3:0] EXTRA_LO   = 4'ha;
    localparam logic [3:0] EXTRA_HI   = 4'he;
    // Port control register addresses
    localparam logic [3:0] IOC_DIR_LO = 4'h5;
    localparam logic [3:0] IOC_DIR_HI = 4'h9;
    localparam logic [3:0] IOC_MODE   = 4'ha;
    localparam logic [3:0] IOC_WAKE   = 4'hb;
    localparam logic [3:0] IOC_LED    = 4'hc;
    localparam logic [3:0] IOC_PULL   = 4'hd;
    localparam logic [3:0] IOC_SPEC   = 4'he;
    // Reset values
    localparam logic [7:0] RST_CTRL   = 8'h3f;
    localparam logic [7:0] RST_MODE   = 8'hc0;
    localparam logic [7:0] RST_WAKE   = 8'hff;
    localparam logic [7:0] RST_LED    = 8'h00;
    localparam logic [7:0] RST_PULL   = 8'hff;
    localparam logic [7:0] RST_SPEC   = 8'hd7;
    localparam logic [7:0] RST_DIR    = 8'hff;
    // Field positions and masks
    localparam int RX_FULL_BIT  = 7;
    localparam int IRQ_DIS_BIT  = 6;
    localparam int LED_BIT      = 7;
    localparam int EXT_SEL_BIT  = 3;
    localparam int PDA_BIT      = 2;
    localparam int RESUME_BIT   = 3;
    localparam int RUN_BIT      = 4;
    localparam int WDT_EN_BIT   = 5;
    localparam int WAKE_DIS_BIT = 6;
    localparam int DUAL_BIT     = 7;
    localparam logic [7:0] PTR_MASK  = 8'h1f;
    localparam logic [7:0] LED_MASK  = 8'h6f;
    localparam logic [7:0] WAKE_ONES = 8'h80;
    localparam logic [7:0] PULL_ONES = 8'h90;
    localparam int FIFO_DEPTH = 32;
endpackage

/* File: rtl/msc_regs.sv */
// Special function and control register bank of the microcontroller
`timescale 1ns/1ps
// Contract
// - Engine write-done sets receive-full; engine blocked
// - Five-bit pointer; bits 7:5 read zero
// - Window reads/writes byte at pointer
// - Timer overflow sets flag bit 0
// - Endpoint-zero command sets flag bit 1
// - Bus suspend sets flag bit 2
// - Bus reset sets flag bit 3
// - Upper port-7 change sets bit 4, non-USB
// - Suspend fall in slow clock sets bit 7
// - Control via own instructions, rest port ones
// - Prescaler fields, each step doubles ratio
// - Bit 6 disables interrupts, instruction driven
// - Bit 7 and LED register enable sinking
// - Direction bit 1 input, 0 output
// - Two mode bits pick operating mode
// - Mode bit 2 enables pattern detect
// - Mode bit 3 redirects 0xA-0xE to extras
// - Mode bits 7:6 pick slow clock
// - Wake select bits active low
// - Pull-high bits active low
// - Resume bit self-clears when bus busy
// - Run bit cleared stops; wake restarts
// - Interrupt needs flag, mask, global enable
module msc_regs (
    input  wire logic                core_clk,   // 20 MHz clock
    input  wire logic                arst_n,     // Async reset, low
    input  wire msc_pkg::msc_req_t   req,        // Core command
    output logic [7:0]               rdData,     // Read data, registered
    output logic                     rdValid,    // Read data pulse
    input  wire msc_pkg::msc_usb_ev_t usbEv,     // Engine events
    input  wire logic                engWr,      // Engine FIFO write
    input  wire logic [4:0]          engAddr,    // Engine FIFO address
    input  wire logic [7:0]          engWrData,  // Engine write byte
    output logic                     engWrReady, // Engine may write
    output logic [7:0]               engRdData,  // Byte at engAddr
    input  wire logic                timerOvf,   // Timer overflow pulse
    input  wire logic [3:0]          upperPort7, // Pins 74..77
    input  wire logic [1:0]          patternEv,  // Pattern one, two
    input  wire logic                wakeSig,    // Wake-up level
    input  wire logic [7:0]          irqMask,    // Interrupt mask
    input  wire logic [7:0]          extRdData,  // Extra bank data
    output logic                     extRd,      // Extra bank read
    output logic                     extWr,      // Extra bank write
    output logic [3:0]               extAddr,    // Extra bank address
    output logic [7:0]               extWrData,  // Extra bank data
    output logic                     irqReq,     // Interrupt request
    output logic [7:0]               wdtRatio,   // Watchdog divide
    output logic [8:0]               tmrRatio,   // Timer divide
    output msc_pkg::msc_pins_t       pins        // Control levels
);
    // Division ratio for a prescaler code
    function automatic logic [8:0] divRatio(input logic [2:0] code,
                                            input logic [8:0] base);
        divRatio = base << code;
    endfunction

    // Storage
    logic [7:0]      fifoMem [msc_pkg::FIFO_DEPTH]; // FIFO bytes
    logic            rxFull;                        // Receive-full flag
    logic [4:0]      fifoPtr;                       // Byte pointer
    logic [7:0]      flags;                         // Interrupt flags
    logic [7:0]      ctrl;                          // Prescaler/control
    logic [4:0][7:0] dirReg;                        // Direction regs
    logic [7:0]      modeReg;                       // Operation mode
    logic [7:0]      wakeReg;                       // Wake select
    logic [7:0]      ledReg;                        // LED sink
    logic [7:0]      pullReg;                       // Pull-high
    logic [7:0]      specReg;                       // Special function
    logic [3:0]      p7Prev;                        // Port-7 history
    logic            suspPrev;                      // Suspend history
    logic            wakePrev;                      // Wake history

    // Command decode
    wire opRd   = req.cmd == msc_pkg::CMD_OP_RD;
    wire opWr   = req.cmd == msc_pkg::CMD_OP_WR;
    wire portRd = req.cmd == msc_pkg::CMD_PORT_RD;
    wire portWr = req.cmd == msc_pkg::CMD_PORT_WR;
    wire ctlRd  = req.cmd == msc_pkg::CMD_CTRL_RD;
    wire ctlWr  = req.cmd == msc_pkg::CMD_CTRL_WR;
    // Extra bank window over operation addresses
    wire inExtra = req.addr >= msc_pkg::EXTRA_LO &&
                   req.addr <= msc_pkg::EXTRA_HI;
    wire extHit  = modeReg[msc_pkg::EXT_SEL_BIT] && inExtra;
    wire opWrLoc = opWr && !extHit;
    wire wrStat  = opWrLoc && req.addr == msc_pkg::OP_STATUS;
    wire wrPtr   = opWrLoc && req.addr == msc_pkg::OP_POINTER;
    wire wrWin   = opWrLoc && req.addr == msc_pkg::OP_WINDOW;
    wire wrFlag  = opWrLoc && req.addr == msc_pkg::OP_FLAGS;
    wire wrDir   = portWr && req.addr >= msc_pkg::IOC_DIR_LO &&
                   req.addr <= msc_pkg::IOC_DIR_HI;
    wire wrMode  = portWr && req.addr == msc_pkg::IOC_MODE;
    wire wrWake  = portWr && req.addr == msc_pkg::IOC_WAKE;
    wire wrLed   = portWr && req.addr == msc_pkg::IOC_LED;
    wire wrPull  = portWr && req.addr == msc_pkg::IOC_PULL;
    wire wrSpec  = portWr && req.addr == msc_pkg::IOC_SPEC;
    wire [2:0] dirIdx = 3'(req.addr - msc_pkg::IOC_DIR_LO);

    // Hardware event terms
    wire slowClk  = !specReg[msc_pkg::DUAL_BIT];
    wire usbMode  = modeReg[1:0] == 2'(msc_pkg::MODE_USB);
    wire p7Change = |(upperPort7 ^ p7Prev) && !usbMode;
    wire resumeEv = slowClk && suspPrev && !usbEv.hostSuspend;
    wire wakeFall = wakePrev && !wakeSig;
    wire [7:0] flagEv = {resumeEv, patternEv[1], patternEv[0], p7Change,
                         usbEv.busReset, usbEv.suspendDet,
                         usbEv.ep0Cmd, timerOvf};

    assign engWrReady = !rxFull;
    wire engWrOk = engWr && !rxFull;

    // Read multiplexers
    logic [7:0] opRdMux;   // Operation register read
    logic [7:0] portRdMux; // Port register read
    always_comb begin
        opRdMux = 8'h00;
        if (extHit) begin
            opRdMux = extRdData;
        end else begin
            case (req.addr)
                msc_pkg::OP_STATUS:  opRdMux = {rxFull, 7'h00};
                msc_pkg::OP_POINTER: opRdMux = {3'h0, fifoPtr};
                msc_pkg::OP_WINDOW:  opRdMux = fifoMem[fifoPtr];
                msc_pkg::OP_FLAGS:   opRdMux = flags;
                default:             opRdMux = 8'h00;
            endcase
        end
    end
    always_comb begin
        portRdMux = 8'h00;
        case (req.addr)
            msc_pkg::IOC_MODE: portRdMux = modeReg;
            msc_pkg::IOC_WAKE: portRdMux = wakeReg | msc_pkg::WAKE_ONES;
            msc_pkg::IOC_LED:  portRdMux = ledReg & msc_pkg::LED_MASK;
            msc_pkg::IOC_PULL: portRdMux = pullReg | msc_pkg::PULL_ONES;
            msc_pkg::IOC_SPEC: portRdMux = specReg;
            default: begin
                if (req.addr >= msc_pkg::IOC_DIR_LO &&
                    req.addr <= msc_pkg::IOC_DIR_HI) begin
                    portRdMux = dirReg[dirIdx];
                end
            end
        endcase
    end
    wire [7:0] next_rdData = ctlRd  ? ctrl :
                             portRd ? portRdMux : opRdMux;

    // Extra bank strobes, combinational handshake
    assign extRd     = opRd && extHit;
    assign extWr     = opWr && extHit;
    assign extAddr   = req.addr;
    assign extWrData = req.wdata;

    // Read data register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdValid <= opRd || portRd || ctlRd;
            if (opRd || portRd || ctlRd) begin
                rdData <= next_rdData;
            end
        end
    end

    // FIFO array, no reset; core write wins address clash
    always_ff @(posedge core_clk) begin
        if (engWrOk) begin
            fifoMem[engAddr] <= engWrData;
        end
        if (wrWin) begin
            fifoMem[fifoPtr] <= req.wdata;
        end
        engRdData <= fifoMem[engAddr];
    end

    // Receive-full flag; set wins over clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxFull <= 1'b0;
        end else if (usbEv.rxDone) begin
            rxFull <= 1'b1;
        end else if (wrStat) begin
            rxFull <= req.wdata[msc_pkg::RX_FULL_BIT];
        end
    end

    // Pointer register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifoPtr <= 5'h00;
        end else if (wrPtr) begin
            fifoPtr <= req.wdata[4:0];
        end
    end

    // Interrupt flags; hardware set wins over firmware write
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= 8'h00;
        end else begin
            flags <= (wrFlag ? req.wdata : flags) | flagEv;
        end
    end

    // Edge history for change detection
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            p7Prev   <= 4'h0;
            suspPrev <= 1'b0;
            wakePrev <= 1'b0;
        end else begin
            p7Prev   <= upperPort7;
            suspPrev <= usbEv.hostSuspend;
            wakePrev <= wakeSig;
        end
    end

    // Control register; bit 6 only through instructions
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= msc_pkg::RST_CTRL;
        end else begin
            if (ctlWr) begin
                ctrl[7] <= req.wdata[7];
                ctrl[5:0] <= req.wdata[5:0];
            end
            if (req.cmd == msc_pkg::CMD_IRQ_DIS) begin
                ctrl[msc_pkg::IRQ_DIS_BIT] <= 1'b1;
            end else if (req.cmd == msc_pkg::CMD_IRQ_EN ||
                         req.cmd == msc_pkg::CMD_IRQ_RET) begin
                ctrl[msc_pkg::IRQ_DIS_BIT] <= 1'b0;
            end
        end
    end

    // Port control registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dirReg  <= {5{msc_pkg::RST_DIR}};
            modeReg <= msc_pkg::RST_MODE;
            wakeReg <= msc_pkg::RST_WAKE;
            ledReg  <= msc_pkg::RST_LED;
            pullReg <= msc_pkg::RST_PULL;
        end else begin
            if (wrDir) begin
                dirReg[dirIdx] <= req.wdata;
            end
            if (wrMode) begin
                modeReg <= req.wdata;
            end
            if (wrWake) begin
                wakeReg <= req.wdata;
            end
            if (wrLed) begin
                ledReg <= req.wdata;
            end
            if (wrPull) begin
                pullReg <= req.wdata;
            end
        end
    end

    // Special function register with hardware-owned bits
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            specReg <= msc_pkg::RST_SPEC;
        end else begin
            if (wrSpec) begin
                specReg <= req.wdata;
            end
            if (!usbEv.busIdle) begin
                specReg[msc_pkg::RESUME_BIT] <= 1'b0;
            end
            if (usbEv.wakeDisSet) begin
                specReg[msc_pkg::WAKE_DIS_BIT] <= 1'b1;
            end
            if (wakeFall) begin
                specReg[msc_pkg::RUN_BIT] <= 1'b1;
            end
        end
    end

    assign irqReq = |(flags & irqMask) && !ctrl[msc_pkg::IRQ_DIS_BIT];

    // Prescaler ratios
    // Watchdog tops out at 128, so bit 8 of its ratio is never set
    wire [8:0] wdtFull = divRatio(ctrl[2:0], 9'h001);
    assign wdtRatio = wdtFull[7:0];
    assign tmrRatio = divRatio(ctrl[5:3], 9'h002);

    // Control levels, all straight from registers
    always_comb begin
        pins.portDirIn           = dirReg;
        pins.opMode              = msc_pkg::msc_mode_t'(modeReg[1:0]);
        pins.patternDetectEnable = modeReg[msc_pkg::PDA_BIT];
        pins.extraBankSelect     = modeReg[msc_pkg::EXT_SEL_BIT];
        pins.dualFreq            = modeReg[7:6];
        pins.p9WakeEn            = ~wakeReg[6:0];
        pins.portWakeEn          = !specReg[msc_pkg::WAKE_DIS_BIT];
        pins.p9LedSink           = ledReg[6:0] & msc_pkg::LED_MASK[6:0];
        pins.upperLedSink        = ctrl[msc_pkg::LED_BIT];
        pins.p9PullEn            = ~pullReg[6:0] & 7'h6f;
        pins.p568PullEn          = ~specReg[2:0];
        pins.deviceResume        = specReg[msc_pkg::RESUME_BIT];
        pins.clockRun            = specReg[msc_pkg::RUN_BIT];
        pins.watchdogEnable      = specReg[msc_pkg::WDT_EN_BIT];
        pins.normalClock         = specReg[msc_pkg::DUAL_BIT];
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_rx_set;
        usbEv.rxDone |=> rxFull && !engWrReady;
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("receive-full not set after write done");

    property p_ptr_zero;
        opRd && !extHit && req.addr == msc_pkg::OP_POINTER
            |=> rdValid && rdData[7:5] == 3'h0;
    endproperty
    a_ptr_zero: assert property (p_ptr_zero)
        else $error("pointer upper bits not zero");

    property p_window;
        opRd && !extHit && req.addr == msc_pkg::OP_WINDOW && !engWrOk
            |=> rdData == fifoMem[$past(fifoPtr)];
    endproperty
    a_window: assert property (p_window)
        else $error("window read not at pointer");

    property p_tmr_sticky;
        timerOvf ##1 !wrFlag [*3] |-> flags[0];
    endproperty
    a_tmr_sticky: assert property (p_tmr_sticky)
        else $error("timer flag lost");

    property p_p7;
        p7Change |=> flags[4];
    endproperty
    a_p7: assert property (p_p7)
        else $error("port change flag not set");

    property p_usb_p7;
        $past(usbMode) && !$past(wrFlag) |-> !$rose(flags[4]);
    endproperty
    a_usb_p7: assert property (p_usb_p7)
        else $error("port change seen in USB mode");

    property p_resume;
        $fell(usbEv.hostSuspend) && slowClk |=> flags[7];
    endproperty
    a_resume: assert property (p_resume)
        else $error("host resume flag not set");

    property p_irq_disable_instr;
        req.cmd == msc_pkg::CMD_IRQ_DIS |=> !irqReq;
    endproperty
    a_irq_disable_instr: assert property (p_irq_disable_instr)
        else $error("interrupt request while disabled");

    property p_irq;
        flags == 8'h00 || irqMask == 8'h00 |-> !irqReq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without cause");

    property p_run;
        wakeFall |=> pins.clockRun;
    endproperty
    a_run: assert property (p_run)
        else $error("run bit not restored on wake");

    property p_resume_bit;
        !usbEv.busIdle |=> !pins.deviceResume;
    endproperty
    a_resume_bit: assert property (p_resume_bit)
        else $error("resume bit held on busy bus");

    c_rx_clear: cover property (rxFull ##1 wrStat ##1 !rxFull);
    c_irq: cover property (!irqReq ##1 irqReq);
    c_extra: cover property (extRd);
    c_sleep: cover property (!pins.clockRun ##[1:20] pins.clockRun);
endmodule // msc_regs

/* File: testbench/msc_core_model.sv */
// Processor core model issuing register commands
`timescale 1ns/1ps
module msc_core_model (
    input  wire logic         core_clk, // Bank clock
    output msc_pkg::msc_req_t req,      // Command to bank
    input  wire logic [7:0]   rdData,   // Read data
    input  wire logic         rdValid   // Read strobe
);
    initial req = '0;
    task automatic op(input msc_pkg::msc_cmd_t c, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        @(negedge core_clk);
        req = '{cmd: c, addr: a, wdata: d};
        @(negedge core_clk);
        req.cmd = msc_pkg::CMD_NONE;
        // Bounded wait; writes simply run out the count
        for (n = 0; n < 3 && rdValid !== 1'b1; n++) @(negedge core_clk);
        q = rdData;
    endtask
    task automatic fifo_put(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] q;
        op(msc_pkg::CMD_OP_WR, msc_pkg::OP_STATUS, 8'h80, q);
        op(msc_pkg::CMD_OP_WR, msc_pkg::OP_POINTER, p, q);
        op(msc_pkg::CMD_OP_WR, msc_pkg::OP_WINDOW, d, q);
    endtask
endmodule // msc_core_model

/* File: testbench/msc_regs_tb.sv */
// Self-checking bench for the special control register bank
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errorCnt++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module msc_regs_tb;
    localparam msc_pkg::msc_cmd_t ORD = msc_pkg::CMD_OP_RD;
    localparam msc_pkg::msc_cmd_t OWR = msc_pkg::CMD_OP_WR;
    localparam msc_pkg::msc_cmd_t PRD = msc_pkg::CMD_PORT_RD;
    localparam msc_pkg::msc_cmd_t PWR = msc_pkg::CMD_PORT_WR;
    localparam msc_pkg::msc_cmd_t CRD = msc_pkg::CMD_CTRL_RD;
    localparam msc_pkg::msc_cmd_t CWR = msc_pkg::CMD_CTRL_WR;
    logic                 core_clk, arst_n, rdValid, engWr, engWrReady;
    logic                 timerOvf, wakeSig, extRd, extWr, irqReq;
    logic [7:0]           rdData, engWrData, engRdData, irqMask, q;
    logic [7:0]           extRdData, extWrData, wdtRatio;
    logic [4:0]           engAddr;
    logic [3:0]           upperPort7, extAddr;
    logic [1:0]           patternEv;
    logic [8:0]           tmrRatio, e;
    logic [16:0]          lfsr = 17'h1817b; // Seed 98683
    msc_pkg::msc_req_t    req;
    msc_pkg::msc_usb_ev_t usbEv;
    msc_pkg::msc_pins_t   pins;
    int                   errorCnt = 0, checksDone = 0, i;
    int                   fifo[32];         // Reference FIFO image
    logic [13:0]          extSeen = '0;     // Last extra-bank strobe
    // Port address and reset value pairs
    logic [15:0] rstTab[7] = '{16'h05ff, 16'h09ff, 16'h0ac0, 16'h0bff,
                               16'h0c00, 16'h0dff, 16'h0ed7};
    msc_regs uut (.core_clk, .arst_n, .req, .rdData, .rdValid, .usbEv,
        .engWr, .engAddr, .engWrData, .engWrReady, .engRdData, .timerOvf,
        .upperPort7, .patternEv, .wakeSig, .irqMask, .extRdData, .extRd,
        .extWr, .extAddr, .extWrData, .irqReq, .wdtRatio, .tmrRatio, .pins);
    msc_core_model cm (.core_clk, .req, .rdData, .rdValid);
    // Extra bank strobes only stand one cycle, so latch them here
    always @(posedge core_clk) begin
        if (extRd || extWr)
            extSeen <= {extRd, extWr, extAddr, extWrData};
    end
    function automatic logic [16:0] step(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction
    task automatic final_report();
        if (errorCnt == 0 && checksDone > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #25 core_clk = ~core_clk;
    end
    // Run needs well under 2000 cycles
    initial begin
        #200000;
        errorCnt++;
        final_report();
    end
    initial begin
        arst_n = 0;
        usbEv = 7'b0000010; // Bus idle
        {engWr, timerOvf, patternEv, engAddr, engWrData, upperPort7} = '0;
        wakeSig = 1;
        irqMask = 8'h01;
        extRdData = 8'h5a;
        repeat (3) @(negedge core_clk);
        arst_n = 1;
        foreach (rstTab[k]) begin
            cm.op(PRD, rstTab[k][11:8], 8'h00, q);
            `CHK(q, rstTab[k][7:0])
        end
        // Reset levels on the control pins
        `CHK(pins.portDirIn, {5{8'hff}})
        `CHK({pins.p9WakeEn, pins.p9PullEn, pins.p568PullEn}, 17'h0)
        `CHK({pins.watchdogEnable, pins.portWakeEn, pins.normalClock}, 3'h1)
        // Port registers written, read back and seen on the pins
        cm.op(PWR, 4'h7, 8'h0f, q);
        cm.op(PRD, 4'h7, 8'h00, q);
        `CHK({q, pins.portDirIn[2]}, 16'h0f0f)
        cm.op(PWR, msc_pkg::IOC_LED, 8'hff, q);
        cm.op(PRD, msc_pkg::IOC_LED, 8'h00, q);
        `CHK({q, pins.p9LedSink}, {8'h6f, 7'h6f})
        cm.op(PWR, msc_pkg::IOC_PULL, 8'h00, q);
        cm.op(PRD, msc_pkg::IOC_PULL, 8'h00, q);
        `CHK({q, pins.p9PullEn}, {8'h90, 7'h6f})
        // Global disable masks a pending flag
        cm.op(msc_pkg::CMD_IRQ_DIS, 4'h0, 8'h00, q);
        timerOvf = 1;
        @(negedge core_clk);
        timerOvf = 0;
        cm.op(CRD, 4'h0, 8'h00, q);
        `CHK({q, irqReq}, 9'h0fe)
        cm.op(msc_pkg::CMD_IRQ_EN, 4'h0, 8'h00, q);
        `CHK(irqReq, 1'b1)
        cm.op(OWR, msc_pkg::OP_FLAGS, 8'h00, q);
        `CHK(irqReq, 1'b0)
        // Every prescaler code; the disable bit ignores writes
        for (i = 0; i < 8; i++) begin
            cm.op(CWR, 4'h0, {i[0], 1'b1, i[2:0], 3'(7 - i)}, q);
            cm.op(CRD, 4'h0, 8'h00, q);
            e = {i[0], 1'b0, i[2:0], 3'(7 - i), i[0]};
            `CHK({q, pins.upperLedSink}, e)
            `CHK({wdtRatio, tmrRatio}, {8'h1 << (7 - i), 9'h2 << i})
        end
        // Flag sources for bits 0 to 6, each alone; the port pin toggles only once
        for (i = 0; i < 7; i++) begin
            {patternEv, e[0], usbEv.busReset, usbEv.suspendDet,
             usbEv.ep0Cmd, timerOvf} = 7'h1 << i;
            upperPort7[0] = upperPort7[0] ^ e[0];
            @(negedge core_clk);
            {patternEv, usbEv.busReset, usbEv.suspendDet, usbEv.ep0Cmd,
             timerOvf} = '0;
            cm.op(ORD, msc_pkg::OP_FLAGS, 8'h00, q);
            `CHK(q, 8'h1 << i)
            cm.op(OWR, msc_pkg::OP_FLAGS, 8'h00, q);
        end
        // Port change ignored in USB mode
        cm.op(PWR, msc_pkg::IOC_MODE, 8'hc1, q);
        upperPort7 = ~upperPort7;
        cm.op(ORD, msc_pkg::OP_FLAGS, 8'h00, q);
        `CHK({q, pins.opMode}, {8'h00, msc_pkg::MODE_USB})
        // Suspend release in slow clock
        cm.op(PWR, msc_pkg::IOC_SPEC, 8'h57, q);
        usbEv.hostSuspend = 1;
        @(negedge core_clk);
        usbEv.hostSuspend = 0;
        cm.op(ORD, msc_pkg::OP_FLAGS, 8'h00, q);
        `CHK(q, 8'h80)
        // Random bytes through the window, seen by both sides
        for (i = 0; i < 6; i++) begin
            lfsr = step(lfsr);
            cm.fifo_put(lfsr[7:0], lfsr[15:8]);
            fifo[lfsr[4:0]] = lfsr[15:8];
            engAddr = lfsr[4:0];
            cm.op(ORD, msc_pkg::OP_POINTER, 8'h00, q);
            `CHK(q, {3'b000, lfsr[4:0]})
            cm.op(ORD, msc_pkg::OP_WINDOW, 8'h00, q);
            `CHK({q, engRdData}, {2{8'(fifo[engAddr])}})
        end
        // Engine refused while the receive flag is set
        engWrData = 8'h3c;
        engWr = 1;
        @(negedge core_clk);
        engWr = 0;
        @(negedge core_clk);
        `CHK({engWrReady, engRdData}, {1'b0, 8'(fifo[engAddr])})
        cm.op(OWR, msc_pkg::OP_STATUS, 8'h00, q);
        engWr = 1;
        fifo[engAddr] = engWrData;
        @(negedge core_clk);
        engWr = 0;
        usbEv.rxDone = 1;
        @(negedge core_clk);
        usbEv.rxDone = 0;
        cm.op(ORD, msc_pkg::OP_STATUS, 8'h00, q);
        e = 9'(fifo[engAddr]);
        `CHK({q, engWrReady, engRdData}, {9'h100, e[7:0]})
        // Extra bank redirect of the operation addresses
        cm.op(PWR, msc_pkg::IOC_MODE, 8'hcd, q);
        cm.op(ORD, 4'hb, 8'h00, q);
        e = {pins.patternDetectEnable, pins.dualFreq, 6'h0};
        `CHK({q, e}, {8'h5a, 3'b111, 6'h0})
        `CHK(extSeen, {2'b10, 4'hb, 8'h00})
        // Redirected status write must leave the receive flag alone
        cm.op(OWR, msc_pkg::OP_STATUS, 8'h25, q);
        `CHK({extSeen, engWrReady}, {2'b01, 4'hc, 8'h25, 1'b0})
        // Resume bit clears on bus activity
        cm.op(PWR, msc_pkg::IOC_SPEC, 8'h5f, q);
        `CHK(pins.deviceResume, 1'b1)
        usbEv.busIdle = 0;
        cm.op(PRD, msc_pkg::IOC_SPEC, 8'h00, q);
        `CHK(q, 8'h57)
        // Sleep, then wake on the falling wake level
        cm.op(PWR, msc_pkg::IOC_SPEC, 8'h47, q);
        `CHK(pins.clockRun, 1'b0)
        wakeSig = 0;
        cm.op(PRD, msc_pkg::IOC_SPEC, 8'h00, q);
        `CHK(q, 8'h57)
        // Read strobe stands exactly one cycle
        `CHK(rdValid, 1'b1)
        @(negedge core_clk);
        `CHK(rdValid, 1'b0)
        final_report();
    end
endmodule // msc_regs_tb
